// *** design/instr_timing_pkg.sv ***
// Package for the instruction length and timing decoder.
// Assumes a single 50 MHz clock domain and 8-bit opcodes.
package instr_timing_pkg;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int unsigned OPC_W      = 8;
    localparam int unsigned LEN_W      = 2;
    localparam int unsigned CYC_W      = 2;
    localparam logic [LEN_W-1:0] LEN_RST = 2'h0;
    localparam logic [CYC_W-1:0] CYC_RST = 2'h0;

    // ------------------------------------------------------------
    // Instruction classes
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        CL_UNKNOWN,
        CL_ORL_DIR_IMM,
        CL_XRL_A_RN,
        CL_XRL_A_DIR,
        CL_XRL_A_IND,
        CL_XRL_A_IMM,
        CL_XRL_DIR_A,
        CL_XRL_DIR_IMM,
        CL_RLC_A,
        CL_RRC_A,
        CL_MOV_A_IND,
        CL_MOV_RN_DIR,
        CL_MOV_RN_IMM,
        CL_MOV_DIR_DIR,
        CL_MOV_DIR_IND,
        CL_MOV_IND_DIR,
        CL_MOV_PTR_IMM,
        CL_CODE_PTR,
        CL_CODE_PC,
        CL_XRD_IND,
        CL_XWR_PTR,
        CL_PUSH_DIR,
        CL_XCHD_IND
    } instr_class_t;

    // ------------------------------------------------------------
    // Opcode encodings of the standard 8-bit instruction set
    // ------------------------------------------------------------
    localparam logic [7:0] OP_ORL_DIR_IMM = 8'h43;
    localparam logic [7:0] OP_XRL_A_RN    = 8'h68;
    localparam logic [7:0] OP_XRL_A_DIR   = 8'h65;
    localparam logic [7:0] OP_XRL_A_IND   = 8'h66;
    localparam logic [7:0] OP_XRL_A_IMM   = 8'h64;
    localparam logic [7:0] OP_XRL_DIR_A   = 8'h62;
    localparam logic [7:0] OP_XRL_DIR_IMM = 8'h63;
    localparam logic [7:0] OP_RLC_A       = 8'h33;
    localparam logic [7:0] OP_RRC_A       = 8'h13;
    localparam logic [7:0] OP_MOV_A_IND   = 8'hE6;
    localparam logic [7:0] OP_MOV_RN_DIR  = 8'hA8;
    localparam logic [7:0] OP_MOV_RN_IMM  = 8'h78;
    localparam logic [7:0] OP_MOV_DIR_DIR = 8'h85;
    localparam logic [7:0] OP_MOV_DIR_IND = 8'h86;
    localparam logic [7:0] OP_MOV_IND_DIR = 8'hA6;
    localparam logic [7:0] OP_MOV_PTR_IMM = 8'h90;
    localparam logic [7:0] OP_CODE_PTR    = 8'h93;
    localparam logic [7:0] OP_CODE_PC     = 8'h83;
    localparam logic [7:0] OP_XRD_IND     = 8'hE2;
    localparam logic [7:0] OP_XWR_PTR     = 8'hF0;
    localparam logic [7:0] OP_PUSH_DIR    = 8'hC0;
    localparam logic [7:0] OP_XCHD_IND    = 8'hD6;

    // Masks clear the register field (Rn: 3 bits, Ri: 1 bit).
    localparam logic [7:0] MASK_RN = 8'hF8;
    localparam logic [7:0] MASK_RI = 8'hFE;
    localparam logic [7:0] MASK_ALL = 8'hFF;

    // ------------------------------------------------------------
    // Byte counts and cycle counts
    // ------------------------------------------------------------
    localparam logic [LEN_W-1:0] LEN_1 = 2'h1;
    localparam logic [LEN_W-1:0] LEN_2 = 2'h2;
    localparam logic [LEN_W-1:0] LEN_3 = 2'h3;
    localparam logic [CYC_W-1:0] CYC_1 = 2'h1;
    localparam logic [CYC_W-1:0] CYC_2 = 2'h2;
    localparam logic [CYC_W-1:0] CYC_3 = 2'h3;

endpackage

// *** design/instr_class_dec.sv ***
// Opcode classifier: maps one opcode byte to an instruction class.
// Assumes the opcode is stable while it is being decoded.
`timescale 1ns/1ps
`default_nettype none
module instr_class_dec (
    // Opcode in
    input  wire logic [7:0]                   opcode,
    // Class out
    output var instr_timing_pkg::instr_class_t   cls
);
    import instr_timing_pkg::*;

    function automatic logic hit(input logic [7:0] op, input logic [7:0] code,
                                 input logic [7:0] mask);
        hit = ((op & mask) == code);
    endfunction

    wire logic h_rn_xrl  = hit(opcode, OP_XRL_A_RN, MASK_RN);
    wire logic h_rn_mdir = hit(opcode, OP_MOV_RN_DIR, MASK_RN);
    wire logic h_rn_mimm = hit(opcode, OP_MOV_RN_IMM, MASK_RN);

    always_comb begin
        cls = CL_UNKNOWN;
        if (hit(opcode, OP_ORL_DIR_IMM, MASK_ALL))      cls = CL_ORL_DIR_IMM;
        else if (h_rn_xrl)                              cls = CL_XRL_A_RN;
        else if (hit(opcode, OP_XRL_A_DIR, MASK_ALL))   cls = CL_XRL_A_DIR;
        else if (hit(opcode, OP_XRL_A_IND, MASK_RI))    cls = CL_XRL_A_IND;
        else if (hit(opcode, OP_XRL_A_IMM, MASK_ALL))   cls = CL_XRL_A_IMM;
        else if (hit(opcode, OP_XRL_DIR_A, MASK_ALL))   cls = CL_XRL_DIR_A;
        else if (hit(opcode, OP_XRL_DIR_IMM, MASK_ALL)) cls = CL_XRL_DIR_IMM;
        else if (hit(opcode, OP_RLC_A, MASK_ALL))       cls = CL_RLC_A;
        else if (hit(opcode, OP_RRC_A, MASK_ALL))       cls = CL_RRC_A;
        else if (hit(opcode, OP_MOV_A_IND, MASK_RI))    cls = CL_MOV_A_IND;
        else if (h_rn_mdir)                             cls = CL_MOV_RN_DIR;
        else if (h_rn_mimm)                             cls = CL_MOV_RN_IMM;
        else if (hit(opcode, OP_MOV_DIR_DIR, MASK_ALL)) cls = CL_MOV_DIR_DIR;
        else if (hit(opcode, OP_MOV_DIR_IND, MASK_RI))  cls = CL_MOV_DIR_IND;
        else if (hit(opcode, OP_MOV_IND_DIR, MASK_RI))  cls = CL_MOV_IND_DIR;
        else if (hit(opcode, OP_MOV_PTR_IMM, MASK_ALL)) cls = CL_MOV_PTR_IMM;
        else if (hit(opcode, OP_CODE_PTR, MASK_ALL))    cls = CL_CODE_PTR;
        else if (hit(opcode, OP_CODE_PC, MASK_ALL))     cls = CL_CODE_PC;
        else if (hit(opcode, OP_XRD_IND, MASK_RI))      cls = CL_XRD_IND;
        else if (hit(opcode, OP_XWR_PTR, MASK_ALL))     cls = CL_XWR_PTR;
        else if (hit(opcode, OP_PUSH_DIR, MASK_ALL))    cls = CL_PUSH_DIR;
        else if (hit(opcode, OP_XCHD_IND, MASK_RI))     cls = CL_XCHD_IND;
    end
endmodule
`default_nettype wire

// *** design/instr_cost_rom.sv ***
// Cost table: bytes and clock cycles for each instruction class.
// Assumes a class from the opcode classifier.
`timescale 1ns/1ps
`default_nettype none
module instr_cost_rom (
    // Class in
    input  wire instr_timing_pkg::instr_class_t cls,
    // Costs out
    output logic [1:0]                          len,
    output logic [1:0]                          cyc,
    output logic                                known
);
    import instr_timing_pkg::*;

    always_comb begin
        len   = LEN_1;
        cyc   = CYC_1;
        known = 1'b1;
        case (cls)
            CL_ORL_DIR_IMM: begin len = LEN_3; cyc = CYC_3; end // RL1
            CL_XRL_A_RN:    begin len = LEN_1; cyc = CYC_1; end // RL2
            CL_XRL_A_DIR:   begin len = LEN_2; cyc = CYC_2; end // RL3
            CL_XRL_A_IND:   begin len = LEN_1; cyc = CYC_2; end // RL4
            CL_XRL_A_IMM:   begin len = LEN_2; cyc = CYC_2; end // RL5
            CL_XRL_DIR_A:   begin len = LEN_2; cyc = CYC_2; end // RL6
            CL_XRL_DIR_IMM: begin len = LEN_3; cyc = CYC_3; end // RL7
            CL_RLC_A:       begin len = LEN_1; cyc = CYC_1; end // RL8
            CL_RRC_A:       begin len = LEN_1; cyc = CYC_1; end // RL9
            CL_MOV_A_IND:   begin len = LEN_1; cyc = CYC_2; end // RL10
            CL_MOV_RN_DIR:  begin len = LEN_2; cyc = CYC_2; end // RL11
            CL_MOV_RN_IMM:  begin len = LEN_2; cyc = CYC_2; end // RL12
            CL_MOV_DIR_DIR: begin len = LEN_3; cyc = CYC_3; end // RL13
            CL_MOV_DIR_IND: begin len = LEN_2; cyc = CYC_2; end // RL14
            CL_MOV_IND_DIR: begin len = LEN_2; cyc = CYC_2; end // RL15
            CL_MOV_PTR_IMM: begin len = LEN_3; cyc = CYC_3; end // RL16
            CL_CODE_PTR:    begin len = LEN_1; cyc = CYC_3; end // RL17
            CL_CODE_PC:     begin len = LEN_1; cyc = CYC_3; end // RL18
            CL_XRD_IND:     begin len = LEN_1; cyc = CYC_3; end // RL19
            CL_XWR_PTR:     begin len = LEN_1; cyc = CYC_3; end // RL20
            CL_PUSH_DIR:    begin len = LEN_2; cyc = CYC_2; end // RL21
            CL_XCHD_IND:    begin len = LEN_1; cyc = CYC_2; end // RL22
            default: begin
                // Unknown opcodes are treated as one-byte, one-cycle no-ops.
                len   = LEN_1;
                cyc   = CYC_1;
                known = 1'b0;
            end
        endcase
    end
endmodule
`default_nettype wire

// *** design/instr_timer.sv ***
// Instruction length and timing sequencer for an 8-bit core.
// Assumes the fetch unit presents an opcode with a valid strobe and
// holds it on the lines, even while fetch_ready is low, until an edge with fetch_ready high takes it.
//
// Notes on behaviour
// (RL1) OR immediate into direct byte: three bytes, three cycles.
// (RL2) XOR register into accumulator: one byte, one cycle.
// (RL3) XOR direct byte into accumulator: two bytes, two cycles.
// (RL4) XOR indirect RAM into accumulator: one byte, two cycles.
// (RL5) XOR immediate into accumulator: two bytes, two cycles.
// (RL6) XOR accumulator into direct byte: two bytes, two cycles.
// (RL7) XOR immediate into direct byte: three bytes, three cycles.
// (RL8) Rotate accumulator left through carry: one byte, one cycle.
// (RL9) Rotate accumulator right through carry: one byte, one cycle.
// (RL10) Load accumulator from indirect RAM: one byte, two cycles.
// (RL11) Copy direct byte to register: two bytes, two cycles.
// (RL12) Load register with immediate: two bytes, two cycles.
// (RL13) Copy direct byte to direct byte: three bytes, three cycles.
// (RL14) Copy indirect RAM to direct byte: two bytes, two cycles.
// (RL15) Copy direct byte to indirect RAM: two bytes, two cycles.
// (RL16) Load data pointer with 16-bit immediate: three bytes, three cycles.
// (RL17) Code read at accumulator plus data pointer: one byte, three cycles.
// (RL18) Code read at accumulator plus program counter: one byte, three cycles.
// (RL19) External read with 8-bit indirect address: one byte, three cycles.
// (RL20) External write at data pointer address: one byte, three cycles.
// (RL21) Push direct byte: two bytes, two cycles.
// (RL22) Exchange low nibble of indirect RAM with accumulator: one byte, two cycles.
// (RL23) Next fetch waits until the current instruction used all its cycles.
`timescale 1ns/1ps
`default_nettype none
module instr_timer (
    // Clock and reset
    input  wire logic                           clk,
    input  wire logic                           srst,
    // Opcode from fetch
    input  wire logic                           opcode_valid,
    input  wire logic [7:0]                     opcode,
    // Handshake back to fetch
    output logic                                fetch_ready,
    // Decoded instruction
    output instr_timing_pkg::instr_class_t      instr_class,
    output logic [1:0]                          instr_len,
    output logic [1:0]                          instr_cyc,
    output logic                                instr_known,
    // Execution progress
    output logic                                busy,
    output logic [1:0]                          cyc_index,
    output logic                                instr_done
);
    import instr_timing_pkg::*;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    typedef enum logic {
        ST_IDLE,
        ST_EXEC
    } seq_state_t;

    instr_class_t cls_dec;
    logic [1:0]   len_dec;
    logic [1:0]   cyc_dec;
    logic         known_dec;

    instr_class_dec u_class (
        .opcode (opcode),
        .cls    (cls_dec)
    );

    instr_cost_rom u_cost (
        .cls    (cls_dec),
        .len    (len_dec),
        .cyc    (cyc_dec),
        .known  (known_dec)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    seq_state_t   state_r;
    seq_state_t   state_nxt;
    logic [1:0]   left_r;
    logic [1:0]   left_nxt;
    logic [1:0]   idx_r;
    logic [1:0]   idx_nxt;
    instr_class_t cls_r;
    logic [1:0]   len_r;
    logic [1:0]   cyc_r;
    logic         known_r;
    logic         ready_r;
    logic         done_r;

    wire logic accept   = (state_r == ST_IDLE) && opcode_valid;
    wire logic last_cyc = (state_r == ST_EXEC) && (left_r == CYC_1);
    // A one-cycle instruction finishes in the cycle it is accepted.
    wire logic one_shot = accept && (cyc_dec == CYC_1);
    wire logic finish   = last_cyc || one_shot;

    always_comb begin
        state_nxt = state_r;
        left_nxt  = left_r;
        idx_nxt   = idx_r;
        case (state_r)
            ST_IDLE: begin
                if (accept && !one_shot) begin
                    state_nxt = ST_EXEC;
                    left_nxt  = 2'(cyc_dec - CYC_1);
                    idx_nxt   = CYC_1;
                end
            end
            ST_EXEC: begin
                if (last_cyc) begin
                    state_nxt = ST_IDLE; // RL23
                    left_nxt  = CYC_RST;
                    idx_nxt   = CYC_RST;
                end else begin
                    left_nxt  = 2'(left_r - CYC_1);
                    idx_nxt   = 2'(idx_r + CYC_1);
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                left_nxt  = CYC_RST;
                idx_nxt   = CYC_RST;
            end
        endcase
    end

    // Ready is registered, so it drops the cycle after a multi-cycle accept (a one-cycle one leaves it high) and
    // rises again only once the final cycle of the instruction is over.
    wire logic ready_nxt = (state_nxt == ST_IDLE); // RL23

    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= ST_IDLE;
            left_r  <= CYC_RST;
            idx_r   <= CYC_RST;
            ready_r <= 1'b1;
            done_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            left_r  <= left_nxt;
            idx_r   <= idx_nxt;
            ready_r <= ready_nxt;
            done_r  <= finish;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cls_r   <= CL_UNKNOWN;
            len_r   <= LEN_RST;
            cyc_r   <= CYC_RST;
            known_r <= 1'b0;
        end else if (accept) begin
            cls_r   <= cls_dec;
            len_r   <= len_dec;
            cyc_r   <= cyc_dec;
            known_r <= known_dec;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic busy_r;
    always_ff @(posedge clk) begin
        if (srst) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= (state_nxt == ST_EXEC);
        end
    end

    assign fetch_ready = ready_r;
    assign instr_class = cls_r;
    assign instr_len   = len_r;
    assign instr_cyc   = cyc_r;
    assign instr_known = known_r;
    assign busy        = busy_r;
    assign cyc_index   = idx_r;
    assign instr_done  = done_r;
endmodule
`default_nettype wire

// *** tb/instr_timer_sva.sv ***
// Checker for the instruction sequencer: decode hold and cycle timing.
// Bound to instr_timer; sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module instr_timer_sva
    import instr_timing_pkg::*;
(
    // Clock and reset
    input wire logic                           clk,
    input wire logic                           srst,
    // Fetch handshake
    input wire logic                           opcode_valid,
    input wire logic                           fetch_ready,
    // Decode and progress
    input wire instr_timing_pkg::instr_class_t instr_class,
    input wire logic [1:0]                     instr_len,
    input wire logic [1:0]                     instr_cyc,
    input wire logic                           busy,
    input wire logic [1:0]                     cyc_index,
    input wire logic                           instr_done
);
    // ----------------------------------------
    // Relations on the rising edge
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    wire logic acc = opcode_valid && fetch_ready;

    a_one_cycle: assert property (acc ##1 (instr_cyc == CYC_1) |->
        (fetch_ready && !busy && instr_done)) else $error("one-cycle timing wrong");
    a_two_cycle: assert property (acc ##1 (instr_cyc == CYC_2) |->
        (busy && !fetch_ready && !instr_done) ##1 (fetch_ready && !busy && instr_done))
        else $error("two-cycle timing wrong");
    a_three_cycle: assert property (acc ##1 (instr_cyc == CYC_3) |->
        (busy && !fetch_ready) [*2] ##1 (fetch_ready && !busy))
        else $error("three-cycle busy span wrong");
    a_three_done: assert property (acc ##1 (instr_cyc == CYC_3) |->
        !instr_done [*2] ##1 instr_done) else $error("three-cycle done wrong");
    a_index_walk: assert property (acc ##1 (instr_cyc == CYC_3) |->
        cyc_index == 2'h1 ##1 cyc_index == 2'h2 ##1 cyc_index == 2'h0)
        else $error("cycle index walk wrong");
    a_busy_blocks: assert property (busy |-> !fetch_ready)
        else $error("fetch allowed while busy");
    a_hold_decode: assert property (!acc |=> $stable({instr_class, instr_len, instr_cyc}))
        else $error("decode changed without accept");
    a_idle_index: assert property (!busy |-> cyc_index == 2'h0)
        else $error("cycle index nonzero while idle");
endmodule

bind instr_timer instr_timer_sva u_sva (
    .clk(clk), .srst(srst), .opcode_valid(opcode_valid), .fetch_ready(fetch_ready),
    .instr_class(instr_class), .instr_len(instr_len), .instr_cyc(instr_cyc),
    .busy(busy), .cyc_index(cyc_index), .instr_done(instr_done)
);
`default_nettype wire

// *** tb/fetch_model.sv ***
// Fetch unit model: presents queued opcodes and holds each until taken.
// Assumes the bench pushes opcodes through the push task.
`timescale 1ns/1ps
`default_nettype none
module fetch_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Bench control
    input  wire logic stall,
    // Handshake with the sequencer
    input  wire logic fetch_ready,
    output logic      opcode_valid,
    output logic [7:0] opcode,
    output logic      taken
);
    // ----------------------------------------
    // Request driver
    // ----------------------------------------
    logic [7:0] q[$];

    task automatic push(input logic [7:0] op);
        q.push_back(op);
    endtask

    initial begin
        opcode_valid = 1'b0;
        opcode = 8'h00;
        taken = 1'b0;
    end

    always @(posedge clk) begin
        taken = opcode_valid && fetch_ready && !srst;
    end

    // A refused opcode stays on the lines until an edge takes it.
    always @(negedge clk) begin
        if (taken || !opcode_valid) begin
            if (q.size() > 0 && !stall) begin
                opcode_valid = 1'b1;
                opcode = q.pop_front();
            end else begin
                // Idle lines toggle so a stale opcode is never mistaken for a request.
                opcode_valid = 1'b0;
                opcode = ~opcode;
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the instruction length and timing sequencer.
// Assumes the package, the design files and the fetch model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import instr_timing_pkg::*;
    // ----------------------------------------
    // Expected costs and bench state
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] op; instr_class_t cls; logic [1:0] len; logic [1:0] cyc;
    } row_t;
    localparam row_t TBL [25] = '{
        '{OP_ORL_DIR_IMM, CL_ORL_DIR_IMM, LEN_3, CYC_3},
        '{OP_XRL_A_RN, CL_XRL_A_RN, LEN_1, CYC_1}, '{8'h6F, CL_XRL_A_RN, LEN_1, CYC_1},
        '{OP_XRL_A_DIR, CL_XRL_A_DIR, LEN_2, CYC_2},
        '{OP_XRL_A_IND, CL_XRL_A_IND, LEN_1, CYC_2}, '{8'h67, CL_XRL_A_IND, LEN_1, CYC_2},
        '{OP_XRL_A_IMM, CL_XRL_A_IMM, LEN_2, CYC_2},
        '{OP_XRL_DIR_A, CL_XRL_DIR_A, LEN_2, CYC_2},
        '{OP_XRL_DIR_IMM, CL_XRL_DIR_IMM, LEN_3, CYC_3},
        '{OP_RLC_A, CL_RLC_A, LEN_1, CYC_1},
        '{OP_RRC_A, CL_RRC_A, LEN_1, CYC_1},
        '{OP_MOV_A_IND, CL_MOV_A_IND, LEN_1, CYC_2},
        '{OP_MOV_RN_DIR, CL_MOV_RN_DIR, LEN_2, CYC_2},
        '{OP_MOV_RN_IMM, CL_MOV_RN_IMM, LEN_2, CYC_2}, '{8'h7D, CL_MOV_RN_IMM, LEN_2, CYC_2},
        '{OP_MOV_DIR_DIR, CL_MOV_DIR_DIR, LEN_3, CYC_3},
        '{OP_MOV_DIR_IND, CL_MOV_DIR_IND, LEN_2, CYC_2},
        '{OP_MOV_IND_DIR, CL_MOV_IND_DIR, LEN_2, CYC_2},
        '{OP_MOV_PTR_IMM, CL_MOV_PTR_IMM, LEN_3, CYC_3},
        '{OP_CODE_PTR, CL_CODE_PTR, LEN_1, CYC_3},
        '{OP_CODE_PC, CL_CODE_PC, LEN_1, CYC_3},
        '{OP_XRD_IND, CL_XRD_IND, LEN_1, CYC_3},
        '{OP_XWR_PTR, CL_XWR_PTR, LEN_1, CYC_3},
        '{OP_PUSH_DIR, CL_PUSH_DIR, LEN_2, CYC_2},
        '{OP_XCHD_IND, CL_XCHD_IND, LEN_1, CYC_2}};
    logic         clk, srst, stall, opcode_valid, fetch_ready, taken;
    logic         instr_known, busy, instr_done;
    logic [7:0]   opcode;
    logic [1:0]   instr_len, instr_cyc, cyc_index;
    instr_class_t instr_class;
    int           mismatches, comparisons, cyc_cnt;
    int           acc_q[$];

    initial clk = 1'b0;
    always #10 clk = ~clk;

    fetch_model u_fetch (.clk(clk), .srst(srst), .stall(stall), .fetch_ready(fetch_ready),
        .opcode_valid(opcode_valid), .opcode(opcode), .taken(taken));
    instr_timer u_dut (.clk(clk), .srst(srst), .opcode_valid(opcode_valid), .opcode(opcode),
        .fetch_ready(fetch_ready), .instr_class(instr_class), .instr_len(instr_len),
        .instr_cyc(instr_cyc), .instr_known(instr_known), .busy(busy),
        .cyc_index(cyc_index), .instr_done(instr_done));

    always @(posedge clk) begin
        cyc_cnt++;
        if (!srst && opcode_valid && fetch_ready) acc_q.push_back(cyc_cnt);
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_taken();
        int n;
        n = 0;
        // Always let one edge pass so a flag left from the last accept is not reused.
        do begin
            @(negedge clk);
            n++;
        end while (taken !== 1'b1 && n < 20);
    endtask

    task automatic run_one(input row_t r);
        int n;
        n = 1;
        u_fetch.push(r.op);
        wait_taken();
        check({instr_class, instr_len, instr_cyc, instr_known},
              {r.cls, r.len, r.cyc, r.cls != CL_UNKNOWN});
        check(fetch_ready, r.cyc == CYC_1);
        // The done pulse stands in the cycle in which fetch may present again.
        while (fetch_ready !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        check(n, r.cyc);
        check(instr_done, 1'b1);
    endtask

    // Opcodes queued while stalled, then sent back to back; a refused one waits.
    task automatic t_back_to_back();
        stall = 1'b1;
        foreach (TBL[i]) if (i == 9 || i == 10 || i == 0 || i == 1 || i == 22) u_fetch.push(TBL[i].op);
        acc_q.delete();
        repeat (2) @(negedge clk);
        check(acc_q.size(), 0);
        stall = 1'b0;
        repeat (16) @(negedge clk);
        check(acc_q.size(), 5);
        check(acc_q[1] - acc_q[0], 3);
        check(acc_q[2] - acc_q[1], 1);
        check(acc_q[3] - acc_q[2], 1);
        check(acc_q[4] - acc_q[3], 1);
        check(instr_class, CL_XWR_PTR);
    endtask

    // Reset in mid-instruction returns the idle state and allows a fresh start.
    task automatic t_reset_mid();
        u_fetch.push(OP_MOV_DIR_DIR);
        wait_taken();
        srst = 1'b1;
        @(negedge clk);
        check({fetch_ready, busy, instr_done, instr_known, cyc_index}, 6'h20);
        check({instr_class, instr_len, instr_cyc}, {CL_UNKNOWN, 4'h0});
        srst = 1'b0;
        @(negedge clk);
        run_one(TBL[4]);
    endtask

    task automatic tally_and_finish();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        srst = 1'b1;
        stall = 1'b0;
        repeat (6) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        foreach (TBL[i]) run_one(TBL[i]);
        run_one('{8'hA5, CL_UNKNOWN, LEN_1, CYC_1});
        t_back_to_back();
        t_reset_mid();
        tally_and_finish();
    end

    // About 100 cycles are needed; the limit leaves ample slack.
    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
